// >>> shared/csf_cfg.svh
`ifndef CSF_CFG_SVH
`define CSF_CFG_SVH

// Register indices; byte address on the AXI4-Lite bus is index * 4
`define CSF_IDX_STATUS   8'h03
`define CSF_IDX_INTERRUPT_CONTROL_REG   8'h0B
`define CSF_IDX_IRQSTAT  8'h10
`define CSF_IDX_IRQMASK  8'h11

// Low seven file-address bits; the upper two bits select the bank
`define CSF_FILE_STATUS  7'h03
`define CSF_FILE_INTERRUPT_CONTROL_REG  7'h0B

// Status field positions
`define CSF_ST_IRP       7
`define CSF_ST_RP1       6
`define CSF_ST_RP0       5
`define CSF_ST_TO        4
`define CSF_ST_PD        3
`define CSF_ST_Z         2
`define CSF_ST_DC        1
`define CSF_ST_C         0

// Interrupt control field positions
`define CSF_IC_GIE       7
`define CSF_IC_TMR0IE    5
`define CSF_IC_EXTIE     4
`define CSF_IC_PORTIE    3
`define CSF_IC_TMR0IF    2
`define CSF_IC_EXTIF     1
`define CSF_IC_PORTIF    0

// Bus interrupt status bits
`define CSF_EV_TIMER0      0
`define CSF_EV_EXT       1
`define CSF_EV_PORT      2
`define CSF_EV_WDT       3
`define CSF_EV_W         4

// Reset values
`define CSF_ST_RST       8'h18
`define CSF_IC_RST       8'h00
`define CSF_EV_RST       4'h0

// AXI responses
`define CSF_RESP_OKAY    2'h0
`define CSF_RESP_DECERR  2'h3

`endif

// >>> shared/csf_pkg.sv
package csf_pkg;

	typedef enum logic [2:0] {
		CSF_OP_NONE  = 3'h0,
		CSF_OP_ADD   = 3'h1,
		CSF_OP_SUB   = 3'h2,
		CSF_OP_AND   = 3'h3,
		CSF_OP_IOR   = 3'h4,
		CSF_OP_XOR   = 3'h5,
		CSF_OP_ZONLY = 3'h6
	} csf_alu_op_t;

	typedef struct packed {
		logic        valid;
		csf_alu_op_t op;
		logic [7:0]  a;
		logic [7:0]  b;
	} csf_alu_req_t;

	typedef struct packed {
		logic z;
		logic dc;
		logic c;
	} csf_flags_t;

	typedef struct packed {
		logic       en;
		logic [8:0] addr;
		logic [7:0] data;
	} csf_file_wr_t;

endpackage

// >>> verilog/csf_alu_flags.sv
`timescale 1ns/100ps
`default_nettype none

module csf_alu_flags (
	input  wire csf_pkg::csf_alu_req_t req,
	output logic [7:0]                 result,
	output var csf_pkg::csf_flags_t    flags,
	output var csf_pkg::csf_flags_t    updMask
);

	logic [8:0] sum9;
	logic [4:0] sum5;

	always_comb begin
		sum9    = 9'h000;
		sum5    = 5'h00;
		result  = req.a;
		updMask = '{z: 1'b0, dc: 1'b0, c: 1'b0};
		unique case (req.op)
			csf_pkg::CSF_OP_ADD: begin
				sum9    = {1'b0, req.a} + {1'b0, req.b};
				sum5    = {1'b0, req.a[3:0]} + {1'b0, req.b[3:0]};
				result  = sum9[7:0];
				updMask = '{z: 1'b1, dc: 1'b1, c: 1'b1};
			end
			csf_pkg::CSF_OP_SUB: begin
				// Two's complement add: carry out set means no borrow
				sum9    = {1'b0, req.a} + {1'b0, ~req.b} + 9'h001;
				sum5    = {1'b0, req.a[3:0]} + {1'b0, ~req.b[3:0]} + 5'h01;
				result  = sum9[7:0];
				updMask = '{z: 1'b1, dc: 1'b1, c: 1'b1};
			end
			csf_pkg::CSF_OP_AND: begin
				result    = req.a & req.b;
				updMask.z = 1'b1;
			end
			csf_pkg::CSF_OP_IOR: begin
				result    = req.a | req.b;
				updMask.z = 1'b1;
			end
			csf_pkg::CSF_OP_XOR: begin
				result    = req.a ^ req.b;
				updMask.z = 1'b1;
			end
			csf_pkg::CSF_OP_ZONLY: begin
				updMask.z = 1'b1;
			end
			default: begin
				result = req.a;
			end
		endcase
		if (!req.valid) begin
			updMask = '{z: 1'b0, dc: 1'b0, c: 1'b0};
		end
		flags.z  = (result == 8'h00);
		flags.dc = sum5[4];
		flags.c  = sum9[8];
	end

endmodule

`default_nettype wire

// >>> verilog/csf_core_status.sv
`timescale 1ns/100ps
`default_nettype none
`include "csf_cfg.svh"

// How it works
// - Instructions that compute Z, DC or C override written values for those bits.
// - Time-out and power-down bits cannot be written by any instruction.
// - Indirect bank bit picks banks 2-3 when 1, banks 0-1 when 0.
// - Two direct bank bits select one of four 128-byte banks.
// - Time-out bit set by power-up, watchdog clear, sleep; cleared by time-out.
// - Power-down bit set by power-up and watchdog clear; cleared by sleep.
// - Zero flag reflects whether an arithmetic or logic result is zero.
// - Digit carry reflects carry out of the low nibble on add/subtract.
// - Carry reflects carry out of the top bit on add/subtract.
// - On subtract, carry and digit carry read 0 for borrow, 1 otherwise.
// - Status answers at file addresses 03h, 83h, 103h and 183h.
// - Interrupt control register holds enables and flags for three sources.
// - Interrupt flags set on their condition regardless of any enable.
// - Global enable off blocks all irqTake interrupts; on allows unmasked ones; the bus irq ignores it.
// - Indirect address is the bank bit above the 8-bit file pointer.
module csf_core_status (
	input  wire logic                    core_clk,
	input  wire logic                    nrst,
	input  wire logic [11:0]             s_axi_awaddr,
	input  wire logic                    s_axi_awvalid,
	output logic                         s_axi_awready,
	input  wire logic [31:0]             s_axi_wdata,
	input  wire logic [3:0]              s_axi_wstrb,
	input  wire logic                    s_axi_wvalid,
	output logic                         s_axi_wready,
	output logic [1:0]                   s_axi_bresp,
	output logic                         s_axi_bvalid,
	input  wire logic                    s_axi_bready,
	input  wire logic [11:0]             s_axi_araddr,
	input  wire logic                    s_axi_arvalid,
	output logic                         s_axi_arready,
	output logic [31:0]                  s_axi_rdata,
	output logic [1:0]                   s_axi_rresp,
	output logic                         s_axi_rvalid,
	input  wire logic                    s_axi_rready,
	input  wire csf_pkg::csf_alu_req_t   aluReq,
	input  wire csf_pkg::csf_file_wr_t   fileWr,
	input  wire logic [8:0]              fileRdAddr,
	output logic [7:0]                   fileRdData,
	output logic [7:0]                   aluResult,
	input  wire logic                    wdtClearExec,
	input  wire logic                    sleepExec,
	input  wire logic                    wdtTimeout,
	input  wire logic                    timer0Ovf,
	input  wire logic                    extPinEdge,
	input  wire logic                    portChange,
	input  wire logic [7:0]              filePointer,
	input  wire logic [6:0]              instrAddr,
	output logic [8:0]                   directAddr,
	output logic [8:0]                   indirectAddr,
	output logic                         irqTake,
	output logic                         irq
);

	logic [7:0]            status_ff;
	logic [7:0]            nxt_status;
	logic [7:0]            interrupt_control_reg_ff;
	logic [7:0]            nxt_interrupt_control_reg;
	logic [3:0]            irqStat_ff;
	logic [3:0]            nxt_irqStat;
	logic [3:0]            irqMask_ff;
	logic [3:0]            nxt_irqMask;
	logic                  bvalid_ff;
	logic                  nxt_bvalid;
	logic [1:0]            bresp_ff;
	logic [1:0]            nxt_bresp;
	logic                  rvalid_ff;
	logic                  nxt_rvalid;
	logic [31:0]           rdata_ff;
	logic [31:0]           nxt_rdata;
	logic [1:0]            rresp_ff;
	logic [1:0]            nxt_rresp;
	logic [7:0]            fileRdData_ff;
	logic [7:0]            nxt_fileRdData;
	logic [7:0]            aluResult_ff;
	logic [7:0]            nxt_aluResult;
	logic [7:0]            aluOut;
	csf_pkg::csf_flags_t   aluFlags;
	csf_pkg::csf_flags_t   aluUpd;
	logic                  wrTake;
	logic                  rdTake;
	logic [9:0]            wrIdx;
	logic [9:0]            rdIdx;
	logic [3:0]            events;

	// Any bank mirrors the register: only the low seven bits are compared
	function automatic logic csf_file_hit(input logic [8:0] addr, input logic [6:0] low);
		csf_file_hit = (addr[6:0] == low);
	endfunction

	function automatic logic csf_bus_hit(input logic [9:0] idx, input logic [7:0] reg_idx);
		csf_bus_hit = (idx == {2'h0, reg_idx});
	endfunction

	csf_alu_flags u_alu (
		.req     (aluReq),
		.result  (aluOut),
		.flags   (aluFlags),
		.updMask (aluUpd)
	);

	assign events[`CSF_EV_TIMER0] = timer0Ovf;
	assign events[`CSF_EV_EXT]  = extPinEdge;
	assign events[`CSF_EV_PORT] = portChange;
	assign events[`CSF_EV_WDT]  = wdtTimeout;

	// Write address and data are taken together; the master holds both until then
	assign wrTake        = s_axi_awvalid && s_axi_wvalid && !bvalid_ff;
	assign s_axi_awready = wrTake;
	assign s_axi_wready  = wrTake;
	assign rdTake        = s_axi_arvalid && !rvalid_ff;
	assign s_axi_arready = rdTake;
	assign wrIdx         = s_axi_awaddr[11:2];
	assign rdIdx         = s_axi_araddr[11:2];

	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp  = bresp_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata  = rdata_ff;
	assign s_axi_rresp  = rresp_ff;
	assign fileRdData   = fileRdData_ff;
	assign aluResult    = aluResult_ff;

	assign directAddr   = {status_ff[`CSF_ST_RP1:`CSF_ST_RP0], instrAddr};
	assign indirectAddr = {status_ff[`CSF_ST_IRP], filePointer};

	assign irqTake = interrupt_control_reg_ff[`CSF_IC_GIE] && (
		(interrupt_control_reg_ff[`CSF_IC_TMR0IE] && interrupt_control_reg_ff[`CSF_IC_TMR0IF]) ||
		(interrupt_control_reg_ff[`CSF_IC_EXTIE] && interrupt_control_reg_ff[`CSF_IC_EXTIF]) ||
		(interrupt_control_reg_ff[`CSF_IC_PORTIE] && interrupt_control_reg_ff[`CSF_IC_PORTIF]));
	assign irq = |(irqStat_ff & irqMask_ff);

	// Register state: status, interrupt control, bus interrupt status and mask
	always_comb begin
		nxt_status  = status_ff;
		nxt_interrupt_control_reg  = interrupt_control_reg_ff;
		nxt_irqStat = irqStat_ff;
		nxt_irqMask = irqMask_ff;
		// Bus writes go first so the core, which owns the register, wins a collision, except on DC and C while an AND, IOR, XOR or Z-only op masks the file write
		if (wrTake && s_axi_wstrb[0]) begin
			if (csf_bus_hit(wrIdx, `CSF_IDX_STATUS)) begin
				nxt_status[`CSF_ST_IRP:`CSF_ST_RP0] = s_axi_wdata[`CSF_ST_IRP:`CSF_ST_RP0];
				nxt_status[`CSF_ST_Z:`CSF_ST_C]     = s_axi_wdata[`CSF_ST_Z:`CSF_ST_C];
			end
			if (csf_bus_hit(wrIdx, `CSF_IDX_INTERRUPT_CONTROL_REG)) begin
				nxt_interrupt_control_reg = s_axi_wdata[7:0];
			end
			if (csf_bus_hit(wrIdx, `CSF_IDX_IRQSTAT)) begin
				nxt_irqStat = irqStat_ff & ~s_axi_wdata[`CSF_EV_W-1:0];
			end
			if (csf_bus_hit(wrIdx, `CSF_IDX_IRQMASK)) begin
				nxt_irqMask = s_axi_wdata[`CSF_EV_W-1:0];
			end
		end
		if (fileWr.en && csf_file_hit(fileWr.addr, `CSF_FILE_STATUS)) begin
			nxt_status[`CSF_ST_IRP:`CSF_ST_RP0] = fileWr.data[`CSF_ST_IRP:`CSF_ST_RP0];
			// Computed flags mask the write on all three bits at once
			if (!(aluUpd.z || aluUpd.dc || aluUpd.c)) begin
				nxt_status[`CSF_ST_Z:`CSF_ST_C] = fileWr.data[`CSF_ST_Z:`CSF_ST_C];
			end
		end
		if (fileWr.en && csf_file_hit(fileWr.addr, `CSF_FILE_INTERRUPT_CONTROL_REG)) begin
			nxt_interrupt_control_reg = fileWr.data;
		end
		if (aluUpd.z) begin
			nxt_status[`CSF_ST_Z] = aluFlags.z;
		end
		if (aluUpd.dc) begin
			nxt_status[`CSF_ST_DC] = aluFlags.dc;
		end
		if (aluUpd.c) begin
			nxt_status[`CSF_ST_C] = aluFlags.c;
		end
		if (wdtClearExec) begin
			nxt_status[`CSF_ST_TO] = 1'b1;
			nxt_status[`CSF_ST_PD] = 1'b1;
		end
		if (sleepExec) begin
			nxt_status[`CSF_ST_TO] = 1'b1;
			nxt_status[`CSF_ST_PD] = 1'b0;
		end
		if (wdtTimeout) begin
			nxt_status[`CSF_ST_TO] = 1'b0;
		end
		// Condition sets win over any clear in the same cycle
		if (timer0Ovf) begin
			nxt_interrupt_control_reg[`CSF_IC_TMR0IF] = 1'b1;
		end
		if (extPinEdge) begin
			nxt_interrupt_control_reg[`CSF_IC_EXTIF] = 1'b1;
		end
		if (portChange) begin
			nxt_interrupt_control_reg[`CSF_IC_PORTIF] = 1'b1;
		end
		nxt_irqStat = nxt_irqStat | events;
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			status_ff  <= `CSF_ST_RST;
			interrupt_control_reg_ff  <= `CSF_IC_RST;
			irqStat_ff <= `CSF_EV_RST;
			irqMask_ff <= `CSF_EV_RST;
		end else begin
			status_ff  <= nxt_status;
			interrupt_control_reg_ff  <= nxt_interrupt_control_reg;
			irqStat_ff <= nxt_irqStat;
			irqMask_ff <= nxt_irqMask;
		end
	end

	// Bus answers and core-side read data
	always_comb begin
		nxt_bvalid     = bvalid_ff;
		nxt_bresp      = bresp_ff;
		nxt_rvalid     = rvalid_ff;
		nxt_rdata      = rdata_ff;
		nxt_rresp      = rresp_ff;
		nxt_aluResult  = aluReq.valid ? aluOut : aluResult_ff;
		nxt_fileRdData = 8'h00;
		if (csf_file_hit(fileRdAddr, `CSF_FILE_STATUS)) begin
			nxt_fileRdData = status_ff;
		end else if (csf_file_hit(fileRdAddr, `CSF_FILE_INTERRUPT_CONTROL_REG)) begin
			nxt_fileRdData = interrupt_control_reg_ff;
		end
		if (bvalid_ff && s_axi_bready) begin
			nxt_bvalid = 1'b0;
		end
		if (wrTake) begin
			nxt_bvalid = 1'b1;
			nxt_bresp  = `CSF_RESP_DECERR;
			if (csf_bus_hit(wrIdx, `CSF_IDX_STATUS) || csf_bus_hit(wrIdx, `CSF_IDX_INTERRUPT_CONTROL_REG) ||
				csf_bus_hit(wrIdx, `CSF_IDX_IRQSTAT) || csf_bus_hit(wrIdx, `CSF_IDX_IRQMASK)) begin
				nxt_bresp = `CSF_RESP_OKAY;
			end
		end
		if (rvalid_ff && s_axi_rready) begin
			nxt_rvalid = 1'b0;
		end
		if (rdTake) begin
			nxt_rvalid = 1'b1;
			nxt_rresp  = `CSF_RESP_OKAY;
			nxt_rdata  = 32'h0000_0000;
			if (csf_bus_hit(rdIdx, `CSF_IDX_STATUS)) begin
				nxt_rdata[7:0] = status_ff;
			end else if (csf_bus_hit(rdIdx, `CSF_IDX_INTERRUPT_CONTROL_REG)) begin
				nxt_rdata[7:0] = interrupt_control_reg_ff;
			end else if (csf_bus_hit(rdIdx, `CSF_IDX_IRQSTAT)) begin
				nxt_rdata[`CSF_EV_W-1:0] = irqStat_ff;
			end else if (csf_bus_hit(rdIdx, `CSF_IDX_IRQMASK)) begin
				nxt_rdata[`CSF_EV_W-1:0] = irqMask_ff;
			end else begin
				nxt_rresp = `CSF_RESP_DECERR;
			end
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			bvalid_ff     <= 1'b0;
			bresp_ff      <= `CSF_RESP_OKAY;
			rvalid_ff     <= 1'b0;
			rdata_ff      <= 32'h0000_0000;
			rresp_ff      <= `CSF_RESP_OKAY;
			fileRdData_ff <= 8'h00;
			aluResult_ff  <= 8'h00;
		end else begin
			bvalid_ff     <= nxt_bvalid;
			bresp_ff      <= nxt_bresp;
			rvalid_ff     <= nxt_rvalid;
			rdata_ff      <= nxt_rdata;
			rresp_ff      <= nxt_rresp;
			fileRdData_ff <= nxt_fileRdData;
			aluResult_ff  <= nxt_aluResult;
		end
	end

	// An add or subtract that also targets status must leave the computed flags
	property p_alu_wins;
		@(posedge core_clk) disable iff (!nrst)
		(aluUpd.c && fileWr.en && fileWr.addr[6:0] == 7'h03)
		|=> (status_ff[2:0] == {$past(aluFlags.z), $past(aluFlags.dc), $past(aluFlags.c)});
	endproperty
	a_alu_wins: assert property (p_alu_wins) else $error("written flags overrode computed flags");
	property p_reset_bits_hold;
		@(posedge core_clk) disable iff (!nrst)
		(!wdtClearExec && !sleepExec && !wdtTimeout) |=> $stable(status_ff[4:3]);
	endproperty
	a_reset_bits_hold: assert property (p_reset_bits_hold) else $error("TO or PD changed without cause");
	property p_timeout_clears;
		@(posedge core_clk) disable iff (!nrst)
		wdtTimeout |=> !status_ff[4];
	endproperty
	a_timeout_clears: assert property (p_timeout_clears) else $error("time-out did not clear TO");
	property p_sleep_sets;
		@(posedge core_clk) disable iff (!nrst)
		(sleepExec && !wdtTimeout) |=> (status_ff[4:3] == 2'h2);
	endproperty
	a_sleep_sets: assert property (p_sleep_sets) else $error("sleep left TO/PD wrong");
	property p_add_carry;
		@(posedge core_clk) disable iff (!nrst)
		(aluReq.valid && aluReq.op == csf_pkg::CSF_OP_ADD)
		|=> (status_ff[0] == (({1'b0, $past(aluReq.a)} + {1'b0, $past(aluReq.b)}) > 9'h0FF));
	endproperty
	a_add_carry: assert property (p_add_carry) else $error("carry wrong after add");
	property p_sub_borrow;
		@(posedge core_clk) disable iff (!nrst)
		(aluReq.valid && aluReq.op == csf_pkg::CSF_OP_SUB)
		|=> (status_ff[0] == ($past(aluReq.a) >= $past(aluReq.b)))
			&& (status_ff[1] == ($past(aluReq.a[3:0]) >= $past(aluReq.b[3:0])));
	endproperty
	a_sub_borrow: assert property (p_sub_borrow) else $error("borrow polarity wrong");
	property p_flag_sets;
		@(posedge core_clk) disable iff (!nrst)
		timer0Ovf |=> interrupt_control_reg_ff[2] && irqStat_ff[0];
	endproperty
	a_flag_sets: assert property (p_flag_sets) else $error("timer0 flag not set");
	// Both directions: a dropped source or a missing global gate fires
	property p_gie_gate;
		@(posedge core_clk) disable iff (!nrst)
		irqTake == (interrupt_control_reg_ff[7] && (|(interrupt_control_reg_ff[5:3] & interrupt_control_reg_ff[2:0])));
	endproperty
	a_gie_gate: assert property (p_gie_gate) else $error("interrupt gating wrong");
	property p_indirect;
		@(posedge core_clk) disable iff (!nrst)
		$rose(status_ff[7]) |-> indirectAddr[8] && directAddr[8:7] == status_ff[6:5];
	endproperty
	a_indirect: assert property (p_indirect) else $error("bank select not applied");
	// Answer appears one cycle after the take and stands until bready
	property p_bresp;
		@(posedge core_clk) disable iff (!nrst)
		(wrTake || (s_axi_bvalid && !s_axi_bready)) |=> s_axi_bvalid;
	endproperty
	a_bresp: assert property (p_bresp) else $error("write answer missing");

endmodule

`default_nettype wire

// >>> sim/csf_core_model.sv
`timescale 1ns/100ps
`default_nettype none

module csf_core_model (
	input  wire logic              core_clk,
	output var csf_pkg::csf_alu_req_t aluReq,
	output var csf_pkg::csf_file_wr_t fileWr,
	output logic [5:0]             evt
);
	initial begin
		aluReq = '0;
		fileWr = '0;
		evt    = '0;
	end

	// One instruction cycle: evt is {port, ext pin, timer0, time-out, sleep, watchdog clear}
	task automatic step(input logic [2:0] op, input logic [7:0] a, input logic [7:0] b,
		input logic wen, input logic [8:0] wa, input logic [7:0] wd, input logic [5:0] ev);
		@(posedge core_clk);
		aluReq <= '{op != 3'h0, csf_pkg::csf_alu_op_t'(op), a, b};
		fileWr <= '{wen, wa, wd}; // Status is normally altered by plain moves
		evt    <= ev;
		@(posedge core_clk);
		// Idle operands are inverted so a stale copy can never look valid
		aluReq <= '{1'b0, csf_pkg::CSF_OP_NONE, ~a, ~b};
		fileWr <= '{1'b0, ~wa, ~wd};
		evt    <= '0;
		@(posedge core_clk);
	endtask
endmodule

`default_nettype wire

// >>> sim/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "csf_cfg.svh"

`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_count++; $display("ERROR at %0t: got %h expected %h", $time, (g), (e)); end end

module testbench;
	logic                  core_clk = 1'b0, nrst = 1'b0;
	logic [11:0]           awaddr = '0, araddr = '0;
	logic                  awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0]           wdata = '0, rdata, dat;
	logic                  awready, wready, bvalid, arready, rvalid, irqTake, irq;
	logic [1:0]            bresp, rresp, resp;
	logic [8:0]            fileRdAddr = '0, directAddr, indirectAddr;
	logic [7:0]            fileRdData, aluResult, filePointer = '0;
	logic [6:0]            instrAddr = '0;
	logic [5:0]            evt;
	csf_pkg::csf_alu_req_t aluReq;
	csf_pkg::csf_file_wr_t fileWr;
	int                    err_count = 0, total_checks = 0, cyc = 0;
	// op, a, b, result, {z, dc, c}
	logic [29:0]           aluTbl [12] = '{{3'h1, 8'hF8, 8'h08, 8'h00, 3'h7}, {3'h1, 8'h01, 8'h01, 8'h02, 3'h0},
		{3'h1, 8'h0F, 8'h01, 8'h10, 3'h2}, {3'h1, 8'h80, 8'h80, 8'h00, 3'h5}, {3'h2, 8'h05, 8'h06, 8'hFF, 3'h0},
		{3'h2, 8'h10, 8'h01, 8'h0F, 3'h1}, {3'h2, 8'h05, 8'h05, 8'h00, 3'h7}, {3'h3, 8'hF0, 8'h0F, 8'h00, 3'h7},
		{3'h4, 8'hF0, 8'h0F, 8'hFF, 3'h3}, {3'h5, 8'hAA, 8'hAA, 8'h00, 3'h7}, {3'h5, 8'hAA, 8'h55, 8'hFF, 3'h3},
		{3'h6, 8'h00, 8'h12, 8'h00, 3'h7}};
	// Event pulse, status afterwards
	logic [13:0]           evTbl [4] = '{{6'h04, 8'h00}, {6'h02, 8'h10}, {6'h06, 8'h00}, {6'h01, 8'h18}};

	always #2 core_clk = ~core_clk;

	csf_core_model core (.core_clk(core_clk), .aluReq(aluReq), .fileWr(fileWr), .evt(evt));

	csf_core_status uut (
		.core_clk(core_clk), .nrst(nrst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .aluReq(aluReq), .fileWr(fileWr),
		.fileRdAddr(fileRdAddr), .fileRdData(fileRdData), .aluResult(aluResult), .wdtClearExec(evt[0]),
		.sleepExec(evt[1]), .wdtTimeout(evt[2]), .timer0Ovf(evt[3]), .extPinEdge(evt[4]), .portChange(evt[5]),
		.filePointer(filePointer), .instrAddr(instrAddr), .directAddr(directAddr),
		.indirectAddr(indirectAddr), .irqTake(irqTake), .irq(irq));

	task automatic axWr(input logic [11:0] a, input logic [7:0] d);
		@(posedge core_clk);
		awaddr  <= a;
		wdata   <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do @(posedge core_clk); while (awready !== 1'b1 || wready !== 1'b1);
		awvalid <= 1'b0;
		wvalid  <= 1'b0;
		do @(posedge core_clk); while (bvalid !== 1'b1);
		resp = bresp;
		bready <= 1'b0;
		`CHK(resp, `CSF_RESP_OKAY)
	endtask

	task automatic axRd(input logic [11:0] a);
		@(posedge core_clk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do @(posedge core_clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge core_clk); while (rvalid !== 1'b1);
		dat = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask

	task automatic rdChk(input logic [11:0] a, input logic [7:0] e);
		axRd(a);
		`CHK(dat, {24'h0, e})
		`CHK(resp, `CSF_RESP_OKAY)
	endtask

	// Called only at a clock edge; read data lands one edge after the address
	task automatic frd(input logic [8:0] a, input logic [7:0] e);
		fileRdAddr <= a;
		repeat (2) @(posedge core_clk);
		`CHK(fileRdData, e)
	endtask

	task automatic results;
		$display("Comparisons %0d, mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Whole run needs well under a thousand cycles
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			err_count++;
			results();
		end
	end

	initial begin
		repeat (8) @(posedge core_clk);
		nrst <= 1'b1;
		rdChk(12'h00C, 8'h18);
		rdChk(12'h02C, 8'h00);
		rdChk(12'h040, 8'h00);
		rdChk(12'h044, 8'h00);
		axRd(12'h008);
		`CHK(resp, `CSF_RESP_DECERR)
		`CHK(dat, 32'h0)
		filePointer <= 8'hA3;
		for (int i = 0; i < 8; i++) begin
			instrAddr <= {i[2:0], 4'h5};
			axWr(12'h00C, {i[2:0], 5'h07});
			rdChk(12'h00C, {i[2:0], 5'h1F});
			`CHK(directAddr, {i[1:0], i[2:0], 4'h5})
			`CHK(indirectAddr, {i[2], 8'hA3})
		end
		axWr(12'h00C, 8'h00);
		for (int b = 0; b < 4; b++) frd({b[1:0], 7'h03}, 8'h18);
		for (int i = 0; i < 12; i++) begin
			core.step(aluTbl[i][29:27], aluTbl[i][26:19], aluTbl[i][18:11], 1'b0, 9'h000, 8'h00, 6'h00);
			`CHK(aluResult, aluTbl[i][10:3])
			frd(9'h003, {5'h03, aluTbl[i][2:0]});
		end
		core.step(3'h1, 8'h01, 8'h01, 1'b1, 9'h103, 8'hE7, 6'h00);
		frd(9'h183, 8'hF8);
		core.step(3'h0, 8'h00, 8'h00, 1'b1, 9'h083, 8'h07, 6'h00);
		frd(9'h003, 8'h1F);
		axWr(12'h00C, 8'hFF);
		core.step(3'h0, 8'h00, 8'h00, 1'b0, 9'h000, 8'h00, 6'h02);
		axWr(12'h00C, 8'h00);
		rdChk(12'h00C, 8'h10);
		for (int i = 0; i < 4; i++) begin
			core.step(3'h0, 8'h00, 8'h00, 1'b0, 9'h000, 8'h00, evTbl[i][13:8]);
			frd(9'h103, evTbl[i][7:0]);
		end
		rdChk(12'h040, 8'h08);
		for (int i = 3; i < 6; i++) core.step(3'h0, 8'h00, 8'h00, 1'b0, 9'h000, 8'h00, 6'(1 << i));
		rdChk(12'h02C, 8'h07);
		`CHK(irqTake, 1'b0)
		`CHK(irq, 1'b0)
		axWr(12'h044, 8'h01);
		`CHK(irq, 1'b1)
		axWr(12'h040, 8'h01);
		`CHK(irq, 1'b0)
		rdChk(12'h040, 8'h0E);
		axWr(12'h044, 8'h0F);
		`CHK(irq, 1'b1)
		axWr(12'h040, 8'h0F);
		`CHK(irq, 1'b0)
		// Stale flags are dropped before the enable goes on
		axWr(12'h02C, 8'h00);
		rdChk(12'h02C, 8'h00);
		axWr(12'h02C, 8'h20);
		core.step(3'h0, 8'h00, 8'h00, 1'b0, 9'h000, 8'h00, 6'h08);
		`CHK(irqTake, 1'b0)
		rdChk(12'h02C, 8'h24);
		axWr(12'h02C, 8'hA4);
		`CHK(irqTake, 1'b1)
		axWr(12'h02C, 8'hB8);
		`CHK(irqTake, 1'b0)
		core.step(3'h0, 8'h00, 8'h00, 1'b0, 9'h000, 8'h00, 6'h10);
		`CHK(irqTake, 1'b1)
		results();
	end
endmodule

`default_nettype wire
